// ### design/ppa_pkg.sv
package ppa_pkg;

    localparam int PORT_W = 8;
    localparam int DATA_W = 32;
    localparam int SEL_W = 4;

    // Register byte offsets
    localparam logic [7:0] OFS_PA_PULL = 8'h00;
    localparam logic [7:0] OFS_PA_ANA = 8'h04;
    localparam logic [7:0] OFS_PB_PULL = 8'h08;
    localparam logic [7:0] OFS_PB_ANA = 8'h0C;
    localparam logic [7:0] OFS_CTRL = 8'h10;
    localparam logic [7:0] OFS_PULL_STAT = 8'h14;
    localparam logic [7:0] OFS_PIN_STAT = 8'h18;

    // Implemented bits of each writable register
    localparam logic [7:0] MASK_PA_PULL = 8'h20;
    localparam logic [7:0] MASK_PA_ANA = 8'h1F;
    localparam logic [7:0] MASK_PB_PULL = 8'hFF;
    localparam logic [7:0] MASK_PB_ANA = 8'hFE;
    localparam logic [7:0] MASK_CTRL = 8'h01;

    // Reset values
    localparam logic [7:0] RST_PA_PULL = 8'h20;
    localparam logic [7:0] RST_PA_ANA = 8'h1F;
    localparam logic [7:0] RST_PB_PULL = 8'hFF;
    localparam logic [7:0] RST_PB_ANA = 8'hFE;
    localparam logic [7:0] RST_CTRL = 8'h01;

    // Field positions
    localparam int CTRL_GPD_BIT = 0;
    localparam int PA_RESET_PIN = 5;
    localparam int STAT_PB_LSB = 8;

    // Synchroniser depth for pin inputs
    localparam int SYNC_STAGES = 2;

endpackage

// ### design/ppa_sync.sv
`timescale 1ns/1ps
`default_nettype none
module ppa_sync #(
    parameter int WIDTH = 16
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [WIDTH-1:0] d_i,
    output logic [WIDTH-1:0] q_o
);
    import ppa_pkg::*;

    generate
        if (WIDTH < 1)
        begin : g_bad_width
            $error("ppa_sync: WIDTH must be at least one");
        end
    endgenerate

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] held;
    } ppa_sync_type;

    ppa_sync_type s_r;
    ppa_sync_type s_nxt;

    // First stage feeds the second stage only
    always_comb
    begin
        s_nxt = s_r;
        s_nxt.meta = d_i;
        s_nxt.held = s_r.meta;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            s_r <= '0;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign q_o = s_r.held;

endmodule
`default_nettype wire

// ### design/ppa_port_cfg.sv
`timescale 1ns/1ps
`default_nettype none
module ppa_port_cfg #(
    parameter int ADDR_W = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADDR_W-1:0] wb_adr_i,
    input wire logic [ppa_pkg::SEL_W-1:0] wb_sel_i,
    input wire logic [ppa_pkg::DATA_W-1:0] wb_dat_i,
    output logic [ppa_pkg::DATA_W-1:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic ext_reset_pin_enable_cfg_i,
    input wire logic [ppa_pkg::PORT_W-1:0] porta_dir_i,
    input wire logic [ppa_pkg::PORT_W-1:0] portb_dir_i,
    input wire logic [ppa_pkg::PORT_W-1:0] porta_pin_i,
    input wire logic [ppa_pkg::PORT_W-1:0] portb_pin_i,
    output logic [ppa_pkg::PORT_W-1:0] porta_pullup_o,
    output logic [ppa_pkg::PORT_W-1:0] portb_pullup_o,
    output logic [ppa_pkg::PORT_W-1:0] porta_analog_sel_o,
    output logic [ppa_pkg::PORT_W-1:0] portb_analog_sel_o,
    output logic [ppa_pkg::PORT_W-1:0] porta_dig_in_en_o,
    output logic [ppa_pkg::PORT_W-1:0] portb_dig_in_en_o
);
    import ppa_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Elaboration checks

    generate
        if (ADDR_W < 5 || ADDR_W > 8)
        begin : g_bad_addr
            $error("ppa_port_cfg: ADDR_W must lie between 5 and 8");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        logic [PORT_W-1:0] pa_pull;
        logic [PORT_W-1:0] pa_ana;
        logic [PORT_W-1:0] pb_pull;
        logic [PORT_W-1:0] pb_ana;
        logic [PORT_W-1:0] ctrl;
        logic ack;
        logic [DATA_W-1:0] rdat;
    } ppa_state_type;

    ppa_state_type st_r;
    ppa_state_type st_nxt;

    ////////////////////////////////////////////////////////////////////////
    // Functions

    // Keeps only implemented bits, so the rest stay zero
    function automatic logic [PORT_W-1:0] keep_impl(
        input logic [PORT_W-1:0] value,
        input logic [PORT_W-1:0] mask
    );
        keep_impl = value & mask;
    endfunction

    // Pull-up is on only for an input pin with the global disable clear
    function automatic logic [PORT_W-1:0] eff_pull(
        input logic [PORT_W-1:0] en,
        input logic [PORT_W-1:0] dir,
        input logic gdis
    );
        eff_pull = en & dir & {PORT_W{~gdis}};
    endfunction

    // Address match against a register offset, high bits beyond ADDR_W cut off
    function automatic logic hit(
        input logic [ADDR_W-1:0] adr,
        input logic [7:0] ofs
    );
        hit = (adr == ofs[ADDR_W-1:0]);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Pin inputs cross into the clock domain

    logic [2*PORT_W-1:0] pins_sync;

    ppa_sync #(
        .WIDTH(2*PORT_W)
    ) u_pin_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i({portb_pin_i, porta_pin_i}),
        .q_o(pins_sync)
    );

    ////////////////////////////////////////////////////////////////////////
    // Pin behaviour

    logic gdis;
    logic [PORT_W-1:0] pa_pull_eff;
    logic [PORT_W-1:0] pb_pull_eff;
    logic [PORT_W-1:0] pa_dig_en;
    logic [PORT_W-1:0] pb_dig_en;
    logic [PORT_W-1:0] pa_pin_seen;
    logic [PORT_W-1:0] pb_pin_seen;

    assign gdis = st_r.ctrl[CTRL_GPD_BIT];

    always_comb
    begin
        // Pin 5 is the only port A pin with a pull-up at all
        pa_pull_eff = eff_pull(st_r.pa_pull, porta_dir_i, gdis);
        // Reset pin keeps its pull-up so the line never floats
        if (ext_reset_pin_enable_cfg_i)
        begin
            pa_pull_eff[PA_RESET_PIN] = 1'b1;
        end
    end

    assign pb_pull_eff = eff_pull(st_r.pb_pull, portb_dir_i, gdis);

    // Analog selection shuts the digital input buffer
    assign pa_dig_en = ~st_r.pa_ana;
    assign pb_dig_en = ~st_r.pb_ana;

    // A disabled buffer reads low, as a real gated buffer would
    assign pa_pin_seen = pins_sync[PORT_W-1:0] & pa_dig_en;
    assign pb_pin_seen = pins_sync[2*PORT_W-1:PORT_W] & pb_dig_en;

    ////////////////////////////////////////////////////////////////////////
    // Register bus

    logic req;
    logic wr_go;
    logic [DATA_W-1:0] rd_mux;

    assign req = wb_cyc_i & wb_stb_i;
    // Write lands at the edge where the master sees ack
    assign wr_go = req & st_r.ack & wb_we_i & wb_sel_i[0];

    always_comb
    begin
        rd_mux = '0;
        if (hit(wb_adr_i, OFS_PA_PULL))
        begin
            rd_mux[PORT_W-1:0] = keep_impl(st_r.pa_pull, MASK_PA_PULL);
        end
        else if (hit(wb_adr_i, OFS_PA_ANA))
        begin
            rd_mux[PORT_W-1:0] = keep_impl(st_r.pa_ana, MASK_PA_ANA);
        end
        else if (hit(wb_adr_i, OFS_PB_PULL))
        begin
            rd_mux[PORT_W-1:0] = keep_impl(st_r.pb_pull, MASK_PB_PULL);
        end
        else if (hit(wb_adr_i, OFS_PB_ANA))
        begin
            rd_mux[PORT_W-1:0] = keep_impl(st_r.pb_ana, MASK_PB_ANA);
        end
        else if (hit(wb_adr_i, OFS_CTRL))
        begin
            rd_mux[PORT_W-1:0] = keep_impl(st_r.ctrl, MASK_CTRL);
        end
        else if (hit(wb_adr_i, OFS_PULL_STAT))
        begin
            rd_mux[PORT_W-1:0] = pa_pull_eff;
            rd_mux[STAT_PB_LSB+PORT_W-1:STAT_PB_LSB] = pb_pull_eff;
        end
        else if (hit(wb_adr_i, OFS_PIN_STAT))
        begin
            rd_mux[PORT_W-1:0] = pa_pin_seen;
            rd_mux[STAT_PB_LSB+PORT_W-1:STAT_PB_LSB] = pb_pin_seen;
        end
        // Unmapped addresses answer with zero and drop writes
    end

    ////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb
    begin
        st_nxt = st_r;
        // One ack per request; it falls the cycle after it rose
        st_nxt.ack = req & ~st_r.ack;
        if (req & ~st_r.ack)
        begin
            st_nxt.rdat = rd_mux;
        end
        if (wr_go)
        begin
            if (hit(wb_adr_i, OFS_PA_PULL))
            begin
                st_nxt.pa_pull = keep_impl(wb_dat_i[PORT_W-1:0],
                    MASK_PA_PULL);
            end
            if (hit(wb_adr_i, OFS_PA_ANA))
            begin
                st_nxt.pa_ana = keep_impl(wb_dat_i[PORT_W-1:0],
                    MASK_PA_ANA);
            end
            if (hit(wb_adr_i, OFS_PB_PULL))
            begin
                st_nxt.pb_pull = keep_impl(wb_dat_i[PORT_W-1:0],
                    MASK_PB_PULL);
            end
            if (hit(wb_adr_i, OFS_PB_ANA))
            begin
                st_nxt.pb_ana = keep_impl(wb_dat_i[PORT_W-1:0],
                    MASK_PB_ANA);
            end
            if (hit(wb_adr_i, OFS_CTRL))
            begin
                st_nxt.ctrl = keep_impl(wb_dat_i[PORT_W-1:0],
                    MASK_CTRL);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            st_r.pa_pull <= RST_PA_PULL;
            st_r.pa_ana <= RST_PA_ANA;
            st_r.pb_pull <= RST_PB_PULL;
            st_r.pb_ana <= RST_PB_ANA;
            st_r.ctrl <= RST_CTRL;
            st_r.ack <= 1'b0;
            st_r.rdat <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    assign wb_ack_o = st_r.ack;
    assign wb_dat_o = st_r.rdat;
    assign porta_pullup_o = pa_pull_eff;
    assign portb_pullup_o = pb_pull_eff;
    // Software is expected to make analog pins inputs; nothing forces it
    assign porta_analog_sel_o = st_r.pa_ana;
    assign portb_analog_sel_o = st_r.pb_ana;
    assign porta_dig_in_en_o = pa_dig_en;
    assign portb_dig_in_en_o = pb_dig_en;

endmodule
`default_nettype wire

// ### dv/ppa_port_cfg_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module ppa_port_cfg_asserts #(
    parameter int ADDR_W = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic wb_ack_o,
    input wire logic ext_reset_pin_enable_cfg_i,
    input wire logic [ppa_pkg::PORT_W-1:0] porta_dir_i,
    input wire logic [ppa_pkg::PORT_W-1:0] portb_dir_i,
    input wire logic [ppa_pkg::PORT_W-1:0] porta_pullup_o,
    input wire logic [ppa_pkg::PORT_W-1:0] portb_pullup_o,
    input wire logic [ppa_pkg::PORT_W-1:0] porta_analog_sel_o,
    input wire logic [ppa_pkg::PORT_W-1:0] portb_analog_sel_o,
    input wire logic [ppa_pkg::PORT_W-1:0] porta_dig_in_en_o,
    input wire logic [ppa_pkg::PORT_W-1:0] portb_dig_in_en_o
);
    import ppa_pkg::*;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    a_pin5_override:
        assert property (ext_reset_pin_enable_cfg_i |-> porta_pullup_o[5])
        else $error("pin 5 pull-up off");
    a_pin5_output_off:
        assert property (!ext_reset_pin_enable_cfg_i && !porta_dir_i[5]
            |-> !porta_pullup_o[5]) else $error("pin 5 pull-up on output");
    a_porta_pull_mask:
        assert property ((porta_pullup_o & 8'hDF) == 8'h00)
        else $error("port A pull-up on absent bit");
    a_portb_output_off:
        assert property ((portb_pullup_o & ~portb_dir_i) == 8'h00)
        else $error("port B pull-up on output");
    a_dig_buffer_off:
        assert property (porta_dig_in_en_o == ~porta_analog_sel_o
            && portb_dig_in_en_o == ~portb_analog_sel_o)
        else $error("digital buffer mismatch");
    a_analog_unimpl:
        assert property (porta_analog_sel_o[7:5] == 3'h0
            && !portb_analog_sel_o[0]) else $error("analog absent bit");
    a_ack_latency:
        assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack late");
    a_ack_single:
        assert property (wb_ack_o |=> !wb_ack_o) else $error("ack long");
    a_ack_no_request:
        assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
        else $error("ack without request");
    a_analog_hold:
        assert property (!(wb_ack_o && wb_we_i) |=> $stable(porta_analog_sel_o)
            && $stable(portb_analog_sel_o)) else $error("analog changed");
    a_reset_values:
        assert property ($fell(rst_i) |-> porta_analog_sel_o == 8'h1F
            && portb_analog_sel_o == 8'hFE) else $error("analog reset");
endmodule
////////////////////////////////////////////////////////////
// Connected by name to the ports of the same names
bind ppa_port_cfg ppa_port_cfg_asserts #(
    .ADDR_W(ADDR_W)
) u_asserts (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_ack_o(wb_ack_o),
    .ext_reset_pin_enable_cfg_i(ext_reset_pin_enable_cfg_i),
    .porta_dir_i(porta_dir_i),
    .portb_dir_i(portb_dir_i),
    .porta_pullup_o(porta_pullup_o),
    .portb_pullup_o(portb_pullup_o),
    .porta_analog_sel_o(porta_analog_sel_o),
    .portb_analog_sel_o(portb_analog_sel_o),
    .porta_dig_in_en_o(porta_dig_in_en_o),
    .portb_dig_in_en_o(portb_dig_in_en_o)
);
`default_nettype wire

// ### dv/ppa_port_cfg_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module ppa_port_cfg_tb_top;
    import ppa_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [SEL_W-1:0] wb_sel_i = 4'hF;
    logic [DATA_W-1:0] wb_dat_i = 32'h0;
    logic [DATA_W-1:0] wb_dat_o;
    logic wb_ack_o;
    logic ext_reset_pin_enable_cfg_i = 1'b0;
    logic [PORT_W-1:0] porta_dir_i = 8'hFF;
    logic [PORT_W-1:0] portb_dir_i = 8'hFF;
    logic [PORT_W-1:0] porta_pin_i = 8'hFF;
    logic [PORT_W-1:0] portb_pin_i = 8'hFF;
    logic [PORT_W-1:0] porta_pullup_o, portb_pullup_o;
    logic [PORT_W-1:0] porta_analog_sel_o, portb_analog_sel_o;
    logic [PORT_W-1:0] porta_dig_in_en_o, portb_dig_in_en_o;
    int miscompares = 0;
    int tests_run = 0;
    ppa_port_cfg dut (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o),
        .ext_reset_pin_enable_cfg_i(ext_reset_pin_enable_cfg_i),
        .porta_dir_i(porta_dir_i),
        .portb_dir_i(portb_dir_i),
        .porta_pin_i(porta_pin_i),
        .portb_pin_i(portb_pin_i),
        .porta_pullup_o(porta_pullup_o),
        .portb_pullup_o(portb_pullup_o),
        .porta_analog_sel_o(porta_analog_sel_o),
        .portb_analog_sel_o(portb_analog_sel_o),
        .porta_dig_in_en_o(porta_dig_in_en_o),
        .portb_dig_in_en_o(portb_dig_in_en_o)
    );
    initial forever #20 clk_i = ~clk_i;
    ////////////////////////////////////////////////////////////
    task automatic end_of_test();
        if (miscompares == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e,
        input logic [31:0] g);
        tests_run++;
        if (g !== e)
        begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Request held until ack is seen; a silent slave ends the run
    task automatic xfer(input logic [7:0] a, input logic w,
        input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        @(posedge clk_i);
        while (wb_ack_o !== 1'b1)
        begin
            n++;
            if (n > 9)
            begin
                miscompares++;
                end_of_test();
            end
            @(posedge clk_i);
        end
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task automatic t_regs();
        logic [31:0] q;
        logic [7:0] ofs [5] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10};
        logic [7:0] msk [5] = '{8'h20, 8'h1F, 8'hFF, 8'hFE, 8'h01};
        for (int i = 0; i < 5; i++)
        begin
            xfer(ofs[i], 1'b0, 32'h0, q);
            chk("reset value", {24'h0, msk[i]}, q);
            xfer(ofs[i], 1'b1, 32'h0, q);
            xfer(ofs[i], 1'b0, 32'h0, q);
            chk("cleared", 32'h0, q);
            xfer(ofs[i], 1'b1, 32'hFFFF_FFFF, q);
            xfer(ofs[i], 1'b0, 32'h0, q);
            chk("all set", {24'h0, msk[i]}, q);
        end
        xfer(8'h1C, 1'b1, 32'hFF, q);
        xfer(8'h1C, 1'b0, 32'h0, q);
        chk("unmapped", 32'h0, q);
    endtask
    task automatic t_pullup();
        logic [31:0] q;
        xfer(8'h10, 1'b1, 32'h0, q);
        @(negedge clk_i);
        chk("pa pull", 32'h20, porta_pullup_o);
        chk("pb pull", 32'hFF, portb_pullup_o);
        xfer(8'h08, 1'b1, 32'hA5, q);
        xfer(8'h00, 1'b1, 32'h0, q);
        portb_dir_i <= 8'h0F;
        @(negedge clk_i);
        chk("pb dir", 32'h05, portb_pullup_o);
        chk("pa off", 32'h0, porta_pullup_o);
        xfer(8'h00, 1'b1, 32'h20, q);
        porta_dir_i <= 8'hDF;
        @(negedge clk_i);
        chk("pa dir", 32'h0, porta_pullup_o);
        @(posedge clk_i);
        ext_reset_pin_enable_cfg_i <= 1'b1;
        xfer(8'h10, 1'b1, 32'h1, q);
        @(negedge clk_i);
        chk("pb global", 32'h0, portb_pullup_o);
        chk("pa forced", 32'h20, porta_pullup_o);
        xfer(8'h14, 1'b0, 32'h0, q);
        chk("pull status", 32'h20, q);
    endtask
    task automatic t_analog();
        logic [31:0] q;
        xfer(8'h04, 1'b1, 32'h0A, q);
        xfer(8'h0C, 1'b1, 32'h83, q);
        // Analog pins must be inputs, so port B pin 7 turns input here
        portb_dir_i <= 8'hFF;
        porta_pin_i <= 8'h3C;
        portb_pin_i <= 8'hC3;
        @(negedge clk_i);
        chk("pa analog", 32'h0A, porta_analog_sel_o);
        chk("pa buffer", 32'hF5, porta_dig_in_en_o);
        chk("pb analog", 32'h82, portb_analog_sel_o);
        chk("pb buffer", 32'h7D, portb_dig_in_en_o);
        // Pin levels reach the status word two edges late
        repeat (2) @(posedge clk_i);
        xfer(8'h18, 1'b0, 32'h0, q);
        chk("pin status", 32'h4134, q);
    endtask
    // Reset in mid-run brings every register back to its reset value
    task automatic t_reset();
        logic [31:0] q;
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(negedge clk_i);
        chk("pa analog reset", 32'h1F, porta_analog_sel_o);
        chk("pb analog reset", 32'hFE, portb_analog_sel_o);
        chk("pb pull reset", 32'h0, portb_pullup_o);
        chk("pa pin5 reset", 32'h20, porta_pullup_o);
        xfer(8'h08, 1'b0, 32'h0, q);
        chk("pb pull reg reset", 32'hFF, q);
    endtask
    ////////////////////////////////////////////////////////////
    initial
    begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs();
        t_pullup();
        t_analog();
        t_reset();
        end_of_test();
    end
endmodule
`default_nettype wire
